// ===== logic/lpmc_pkg.sv
// constants and types for the low power mode controller
`default_nettype none
package lpmc_pkg;
    localparam logic [31:0] LPMC_SCR_ADDR     = 32'hE000ED10;
    localparam logic [31:0] LPMC_SCR_RESET    = 32'h00000000;
    localparam int          LPMC_SCR_ISR_BIT  = 1;
    localparam int          LPMC_SCR_DEEP_BIT = 2;
    localparam int          LPMC_SCR_PEND_BIT = 4;
    localparam logic [31:0] LPMC_SCR_MASK     = 32'h00000016;
    localparam logic [11:0] LPMC_PMU_BASE     = 12'h000;
    localparam logic [11:0] LPMC_POWER_MODE_SELECT_REG_OFF     = 12'h000;
    localparam logic [11:0] LPMC_RET0_OFF     = 12'h004;
    localparam logic [11:0] LPMC_DPD_OFF      = 12'h014;
    localparam logic [31:0] LPMC_PMU_RESET    = 32'h00000000;
    localparam int          LPMC_RET_COUNT    = 4;
    // power_mode_select_reg fields
    localparam logic [2:0]  LPMC_PM_DEFAULT   = 3'h0;
    localparam logic [2:0]  LPMC_PM_DSLEEP    = 3'h1;
    localparam logic [2:0]  LPMC_PM_PDOWN     = 3'h2;
    localparam logic [2:0]  LPMC_PM_DPD       = 3'h3;
    localparam int          LPMC_POWER_MODE_SELECT_REG_SLPF    = 8;
    localparam int          LPMC_POWER_MODE_SELECT_REG_DPDF    = 11;
    // deep_off_control_reg fields
    localparam int          LPMC_DPD_WAKE_DIS = 0;
    localparam int          LPMC_DPD_TMR_EN   = 2;
    localparam int          LPMC_PULSE_MIN    = 2;
    typedef enum logic [5:0] {
        LPMC_ACTIVE  = 6'h01,
        LPMC_SLEEP   = 6'h02,
        LPMC_DSLEEP  = 6'h04,
        LPMC_PDOWN   = 6'h08,
        LPMC_DPD     = 6'h10,
        LPMC_REBOOT  = 6'h20
    } lpmc_state_t;
endpackage
`default_nettype wire

// ===== logic/lpmc_wake_filter.sv
// pulse qualifier for the external wake pin
`default_nettype none
module lpmc_wake_filter
    import lpmc_pkg::*;
#(
    parameter int MIN_LOW = LPMC_PULSE_MIN
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // pin side
    input  wire logic enable,
    input  wire logic pin_level,
    // result
    output logic      pulse_seen
);
    logic [7:0] low_cnt_reg;
    logic       pulse_seen_reg;

    // low level must last to reject glitches on the pin
    always_ff @(posedge clk) begin
        if (reset || !enable || pin_level) begin
            low_cnt_reg <= 8'h00;
        end else if (low_cnt_reg != 8'(MIN_LOW)) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pulse_seen_reg <= 1'b0;
        end else begin
            pulse_seen_reg <= enable && (low_cnt_reg == 8'(MIN_LOW - 1))
                              && !pin_level;
        end
    end

    assign pulse_seen = pulse_seen_reg;
endmodule
`default_nettype wire

// ===== logic/lpmc_core.sv
// low power mode controller: core sleep control and power sequencing
`default_nettype none
module lpmc_core
    import lpmc_pkg::*;
#(
    parameter int WAKE_PULSE_MIN = LPMC_PULSE_MIN
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // core private bus access to core_sleep_control
    input  wire logic        ppb_sel,
    input  wire logic        ppb_write,
    input  wire logic [31:0] ppb_addr,
    input  wire logic [31:0] ppb_wdata,
    output logic      [31:0] ppb_rdata,
    // power_management_unit register port
    input  wire logic        pmu_sel,
    input  wire logic        pmu_write,
    input  wire logic [11:0] pmu_addr,
    input  wire logic [31:0] pmu_wdata,
    output logic      [31:0] pmu_rdata,
    // core instruction and exception events
    input  wire logic        wait_irq_instruction,
    input  wire logic        wait_event_instruction,
    input  wire logic        send_event_instruction,
    input  wire logic        isr_return_to_thread,
    // interrupt sources
    input  wire logic        irq_pending_enabled,
    input  wire logic        irq_pending_disabled,
    input  wire logic        event_in,
    input  wire logic        deep_wake_source,
    // deep power-down wake sources
    input  wire logic        external_wake_pin,
    input  wire logic        self_wake_timer_timeout,
    // power controls
    output logic             core_clk_en,
    output logic             periph_clk_en,
    output logic             flash_standby,
    output logic             flash_power_en,
    output logic             retention_en,
    output logic             system_power_en,
    output logic             monitors_en,
    output logic             self_wake_timer_en,
    output logic             pin_inputs_en,
    output logic             reboot_req,
    output logic             event_latched,
    output lpmc_state_t      power_state
);
    logic [31:0]  scr_reg;
    logic [31:0]  power_mode_select_reg_reg;
    logic [31:0]  dpd_reg;
    logic [31:0]  ret_reg [LPMC_RET_COUNT];
    logic         event_reg;
    logic         waiting_event_reg;
    lpmc_state_t  state_reg;
    lpmc_state_t  state_next;
    logic         scr_wr;
    logic         pmu_wr;
    logic         wake_any;
    logic         new_event;
    logic         sleep_req;
    logic         dpd_wake;
    logic         pin_pulse;
    logic         pin_wake_enable;
    logic [2:0]   pm_field;

    assign scr_wr = ppb_sel && ppb_write && (ppb_addr == LPMC_SCR_ADDR);
    assign pmu_wr = pmu_sel && pmu_write && (state_reg != LPMC_DPD);
    assign pm_field = power_mode_select_reg_reg[2:0];

    always_ff @(posedge clk) begin
        if (reset) begin
            scr_reg <= LPMC_SCR_RESET;
        end else if (scr_wr) begin
            scr_reg <= ppb_wdata & LPMC_SCR_MASK;
        end
    end

    always_comb begin
        ppb_rdata = 32'h00000000;
        if (ppb_sel && ppb_addr == LPMC_SCR_ADDR) begin
            ppb_rdata = scr_reg;
        end
    end

    // disabled interrupts only count when enabled by bit
    // send event is one more source
    assign new_event = event_in || irq_pending_enabled
                       || send_event_instruction
                       || (scr_reg[LPMC_SCR_PEND_BIT]
                           && irq_pending_disabled);

    // latch event when no wfe wait is in progress; set wins
    always_ff @(posedge clk) begin
        if (reset) begin
            event_reg <= 1'b0;
        end else if (new_event && !waiting_event_reg) begin
            event_reg <= 1'b1;
        end else if (wait_event_instruction && state_reg == LPMC_ACTIVE) begin
            event_reg <= 1'b0;
        end
    end
    assign event_latched = event_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            waiting_event_reg <= 1'b0;
        end else if (state_reg == LPMC_ACTIVE) begin
            waiting_event_reg <= sleep_req && wait_event_instruction;
        end else if (wake_any) begin
            waiting_event_reg <= 1'b0;
        end
    end

    // entry only on wait instructions or isr return
    // handler return sleeps when bit set
    // a latched event makes a wfe return at once
    assign sleep_req = wait_irq_instruction
                       || (wait_event_instruction && !event_reg)
                       || (isr_return_to_thread
                           && scr_reg[LPMC_SCR_ISR_BIT]);

    // wake from wfi on interrupts; wfe on events
    assign wake_any = waiting_event_reg ? new_event
                      : (irq_pending_enabled || deep_wake_source
                         || (scr_reg[LPMC_SCR_PEND_BIT]
                             && irq_pending_disabled));

    // wake pin disable bit in deep_off_control_reg
    assign pin_wake_enable = !dpd_reg[LPMC_DPD_WAKE_DIS];

    lpmc_wake_filter #(
        .MIN_LOW (WAKE_PULSE_MIN)
    ) u_wake_filter (
        .clk       (clk),
        .reset     (reset),
        .enable    (pin_wake_enable && state_reg == LPMC_DPD),
        .pin_level (external_wake_pin),
        .pulse_seen(pin_pulse)
    );

    // pin pulse or timer timeout leaves deep off
    assign dpd_wake = pin_pulse
                      || (dpd_reg[LPMC_DPD_TMR_EN] && self_wake_timer_timeout);

    // transitions only on core requests or wake events, except reboot, which always returns to active on the next cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LPMC_ACTIVE: begin
                if (sleep_req) begin
                    // deep select chooses ordinary or deep
                    if (!scr_reg[LPMC_SCR_DEEP_BIT]) begin
                        state_next = LPMC_SLEEP;
                    end else begin
                        case (pm_field)
                            LPMC_PM_DSLEEP: state_next = LPMC_DSLEEP;
                            LPMC_PM_PDOWN:  state_next = LPMC_PDOWN;
                            LPMC_PM_DPD:    state_next = LPMC_DPD;
                            default:        state_next = LPMC_DSLEEP;
                        endcase
                    end
                end
            end
            LPMC_SLEEP, LPMC_DSLEEP, LPMC_PDOWN: begin
                if (wake_any) begin
                    state_next = LPMC_ACTIVE;
                end
            end
            LPMC_DPD: begin
                if (dpd_wake) begin
                    state_next = LPMC_REBOOT;
                end
            end
            LPMC_REBOOT: begin
                state_next = LPMC_ACTIVE;
            end
            default: state_next = LPMC_ACTIVE;
        endcase
    end

    // sequencer never gated in any mode
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= LPMC_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end
    assign power_state = state_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            power_mode_select_reg_reg <= LPMC_PMU_RESET;
        end else begin
            if (pmu_wr && pmu_addr == LPMC_POWER_MODE_SELECT_REG_OFF) begin
                power_mode_select_reg_reg[2:0] <= pmu_wdata[2:0];
                // flags clear by writing one
                if (pmu_wdata[LPMC_POWER_MODE_SELECT_REG_SLPF]) begin
                    power_mode_select_reg_reg[LPMC_POWER_MODE_SELECT_REG_SLPF] <= 1'b0;
                end
                if (pmu_wdata[LPMC_POWER_MODE_SELECT_REG_DPDF]) begin
                    power_mode_select_reg_reg[LPMC_POWER_MODE_SELECT_REG_DPDF] <= 1'b0;
                end
            end
            // set wins over a clear in the same cycle
            if (state_next == LPMC_SLEEP || state_next == LPMC_DSLEEP
                || state_next == LPMC_PDOWN) begin
                if (state_reg == LPMC_ACTIVE) begin
                    power_mode_select_reg_reg[LPMC_POWER_MODE_SELECT_REG_SLPF] <= 1'b1;
                end
            end
            if (state_reg == LPMC_DPD && state_next == LPMC_REBOOT) begin
                power_mode_select_reg_reg[LPMC_POWER_MODE_SELECT_REG_DPDF] <= 1'b1;
                // mode select returns to default on reboot
                power_mode_select_reg_reg[2:0] <= LPMC_PM_DEFAULT;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            dpd_reg <= LPMC_PMU_RESET;
        end else if (pmu_wr && pmu_addr == LPMC_DPD_OFF) begin
            dpd_reg <= {29'h0, pmu_wdata[2:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < LPMC_RET_COUNT; i++) begin
                ret_reg[i] <= LPMC_PMU_RESET;
            end
        end else if (pmu_wr) begin
            for (int i = 0; i < LPMC_RET_COUNT; i++) begin
                if (pmu_addr == LPMC_RET0_OFF + 12'(4 * i)) begin
                    ret_reg[i] <= pmu_wdata;
                end
            end
        end
    end

    always_comb begin
        pmu_rdata = 32'h00000000;
        if (pmu_sel) begin
            if (pmu_addr == LPMC_POWER_MODE_SELECT_REG_OFF) begin
                pmu_rdata = power_mode_select_reg_reg;
            end else if (pmu_addr == LPMC_DPD_OFF) begin
                pmu_rdata = dpd_reg;
            end
            for (int i = 0; i < LPMC_RET_COUNT; i++) begin
                if (pmu_addr == LPMC_RET0_OFF + 12'(4 * i)) begin
                    pmu_rdata = ret_reg[i];
                end
            end
        end
    end

    // power control outputs from flip-flops
    always_ff @(posedge clk) begin
        if (reset) begin
            core_clk_en        <= 1'b1;
            periph_clk_en      <= 1'b1;
            flash_standby      <= 1'b0;
            flash_power_en     <= 1'b1;
            retention_en       <= 1'b1;
            system_power_en    <= 1'b1;
            monitors_en        <= 1'b1;
            self_wake_timer_en <= 1'b1;
            pin_inputs_en      <= 1'b1;
            reboot_req         <= 1'b0;
        end else begin
            core_clk_en        <= state_next == LPMC_ACTIVE;
            periph_clk_en      <= state_next == LPMC_ACTIVE
                                  || state_next == LPMC_SLEEP;
            flash_standby      <= state_next == LPMC_DSLEEP;
            // flash off in power-down and deep off
            flash_power_en     <= state_next != LPMC_PDOWN
                                  && state_next != LPMC_DPD;
            system_power_en    <= state_next != LPMC_DPD;
            retention_en       <= 1'b1;
            monitors_en        <= state_next != LPMC_DPD;
            self_wake_timer_en <= state_next != LPMC_DPD
                                  || dpd_reg[LPMC_DPD_TMR_EN];
            // pin inputs dead in deep off
            pin_inputs_en      <= state_next != LPMC_DPD;
            reboot_req         <= state_next == LPMC_REBOOT;
        end
    end
endmodule
`default_nettype wire

// ===== verification/lpmc_core_properties.sv
// concurrent checks on the low power mode controller ports
`default_nettype none
module lpmc_core_properties
    import lpmc_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // core register bus
    input wire logic        ppb_sel,
    input wire logic        ppb_write,
    input wire logic [31:0] ppb_addr,
    input wire logic [31:0] ppb_wdata,
    input wire logic [31:0] ppb_rdata,
    // core events
    input wire logic        wait_irq_instruction,
    input wire logic        wait_event_instruction,
    input wire logic        isr_return_to_thread,
    input wire logic        irq_pending_enabled,
    input wire logic        irq_pending_disabled,
    // power controls
    input wire logic        core_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        flash_standby,
    input wire logic        flash_power_en,
    input wire logic        retention_en,
    input wire logic        pin_inputs_en,
    input wire logic        reboot_req,
    input wire lpmc_state_t power_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // shadow of the writable bits, reserved bits dropped
    logic [31:0] scr_copy_reg;
    always_ff @(posedge clk) begin
        if (reset) begin
            scr_copy_reg <= LPMC_SCR_RESET;
        end else if (ppb_sel && ppb_write && ppb_addr == LPMC_SCR_ADDR) begin
            scr_copy_reg <= ppb_wdata & LPMC_SCR_MASK;
        end
    end
    a_scr_readback: assert property (
        ppb_sel && !ppb_write && ppb_addr == LPMC_SCR_ADDR
        |-> ppb_rdata == scr_copy_reg) else $error("scr readback wrong");
    a_entry_by_core: assert property (
        power_state == LPMC_ACTIVE && !wait_irq_instruction
        && !wait_event_instruction && !isr_return_to_thread
        |=> power_state == LPMC_ACTIVE) else $error("sleep without core");
    a_wfi_plain_sleep: assert property (
        power_state == LPMC_ACTIVE && wait_irq_instruction
        && !scr_copy_reg[2] |=> power_state == LPMC_SLEEP)
        else $error("wfi did not sleep");
    a_sleep_core_only: assert property (
        power_state == LPMC_SLEEP |-> !core_clk_en && periph_clk_en
        && flash_power_en) else $error("sleep gating wrong");
    a_dsleep_standby: assert property (
        power_state == LPMC_DSLEEP |-> !periph_clk_en && flash_standby
        && retention_en) else $error("deep-sleep gating wrong");
    a_pdown_flash_off: assert property (
        power_state == LPMC_PDOWN |-> !periph_clk_en && !flash_power_en
        && retention_en) else $error("power-down gating wrong");
    a_deep_off_pins: assert property (
        power_state == LPMC_DPD |-> !periph_clk_en && !pin_inputs_en
        && retention_en) else $error("deep off gating wrong");
    a_reboot_then_active: assert property (
        power_state == LPMC_REBOOT |-> reboot_req
        ##1 power_state == LPMC_ACTIVE) else $error("reboot exit wrong");
    a_wake_to_active: assert property (
        power_state == LPMC_SLEEP && irq_pending_enabled
        |=> power_state == LPMC_ACTIVE) else $error("no wake");
    a_pending_any_wake: assert property (
        power_state == LPMC_SLEEP && irq_pending_disabled
        && scr_copy_reg[4] |=> power_state == LPMC_ACTIVE)
        else $error("disabled irq did not wake");
endmodule
`default_nettype wire

// ===== verification/lpmc_core_model.sv
// behavioural processor core issuing sleep and event instructions
`default_nettype none
module lpmc_core_model (
    // clock
    input  wire logic clk,
    // instruction pulses
    output logic      wfi_pulse,
    output logic      wfe_pulse,
    output logic      sev_pulse,
    output logic      ret_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {wfi_pulse, wfe_pulse, sev_pulse, ret_pulse} = 4'h0;
    end
    task automatic issue(input logic [3:0] op);
        @(negedge clk);
        {wfi_pulse, wfe_pulse, sev_pulse, ret_pulse} = op;
        @(negedge clk);
        {wfi_pulse, wfe_pulse, sev_pulse, ret_pulse} = 4'h0;
    endtask
endmodule
`default_nettype wire

// ===== verification/tb_lpmc_core.sv
// self-checking bench for the low power mode controller
`default_nettype none
module tb_lpmc_core
    import lpmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, reset, ppb_sel, ppb_write, pmu_sel, pmu_write;
    logic [31:0] ppb_addr, ppb_wdata, ppb_rdata, pmu_wdata, pmu_rdata;
    logic [11:0] pmu_addr;
    logic        wait_irq_instruction, wait_event_instruction;
    logic        send_event_instruction, isr_return_to_thread;
    logic        irq_pending_enabled, irq_pending_disabled, event_in;
    logic        deep_wake_source, external_wake_pin;
    logic        self_wake_timer_timeout, core_clk_en, periph_clk_en;
    logic        flash_standby, flash_power_en, retention_en;
    logic        system_power_en, monitors_en, self_wake_timer_en;
    logic        pin_inputs_en, reboot_req, event_latched;
    lpmc_state_t power_state;
    int          n_mismatch, checks, cyc, n_reboot;
    logic [31:0] seed, v, rv [4];
    lpmc_state_t exp_m [3] = '{LPMC_SLEEP, LPMC_DSLEEP, LPMC_PDOWN};
    lpmc_core i_dut (.*);
    lpmc_core_model i_core (.clk(clk), .wfi_pulse(wait_irq_instruction),
        .wfe_pulse(wait_event_instruction),
        .sev_pulse(send_event_instruction),
        .ret_pulse(isr_return_to_thread));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_st(input lpmc_state_t e);
        checks++;
        if (power_state !== e) begin
            n_mismatch++;
            $display("unexpected t=%0t got %h exp %h", $time, power_state, e);
        end
    endtask
    task automatic ppb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(negedge clk);
        {ppb_sel, ppb_write, ppb_addr, ppb_wdata} = {1'b1, w, a, d};
        @(negedge clk);
        r = ppb_rdata;
        {ppb_sel, ppb_write} = 2'h0;
    endtask
    task automatic power_management_unit(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(negedge clk);
        {pmu_sel, pmu_write, pmu_addr, pmu_wdata} = {1'b1, w, a, d};
        @(negedge clk);
        r = pmu_rdata;
        {pmu_sel, pmu_write} = 2'h0;
    endtask
    // one-cycle source: 0 irq, 1 disabled irq, 2 event, 3 deep, 4 timer
    task automatic pulse(input int k);
        @(negedge clk);
        {irq_pending_enabled, irq_pending_disabled, event_in,
         deep_wake_source, self_wake_timer_timeout} = 5'h10 >> k;
        @(negedge clk);
        {irq_pending_enabled, irq_pending_disabled, event_in,
         deep_wake_source, self_wake_timer_timeout} = 5'h00;
    endtask
    // pin low longer than the qualifier needs, pulled up after
    task automatic pin_low;
        @(negedge clk);
        external_wake_pin = 1'b0;
        repeat (3) @(negedge clk);
        external_wake_pin = 1'b1;
        for (int i = 0; i < 20 && power_state !== LPMC_ACTIVE; i++) begin
            @(negedge clk);
        end
    endtask
    task automatic report_and_stop;
        $display("n_mismatch %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (reboot_req === 1'b1) n_reboot++;
        // bounded run, a hang counts against the result
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        {ppb_sel, ppb_write, pmu_sel, pmu_write, ppb_addr} = 36'h0;
        {ppb_wdata, pmu_wdata, pmu_addr} = 76'h0;
        {irq_pending_enabled, irq_pending_disabled, event_in} = 3'h0;
        {deep_wake_source, self_wake_timer_timeout} = 2'h0;
        external_wake_pin = 1'b1;
        seed = 32'h485A;
        reset = 1'b1;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        ppb(1'b0, LPMC_SCR_ADDR, 32'h0, v); chk(v, LPMC_SCR_RESET);
        power_management_unit(1'b0, LPMC_POWER_MODE_SELECT_REG_OFF, 32'h0, v); chk(v, LPMC_PMU_RESET);
        power_management_unit(1'b0, 12'h018, 32'h0, v); chk(v, 32'h0);
        ppb(1'b0, 32'hE000ED14, 32'h0, v); chk(v, 32'h0);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            ppb(1'b1, LPMC_SCR_ADDR, seed, v);
            ppb(1'b0, LPMC_SCR_ADDR, 32'h0, v);
            chk(v, seed & LPMC_SCR_MASK);
        end
        for (int m = 0; m < 3; m++) begin
            ppb(1'b1, LPMC_SCR_ADDR, (m == 0) ? 32'h0 : 32'h4, v);
            power_management_unit(1'b1, LPMC_POWER_MODE_SELECT_REG_OFF, 32'(m), v);
            i_core.issue(4'h8);
            chk_st(exp_m[m]);
            chk({31'h0, periph_clk_en}, {31'h0, m == 0});
            pulse((m == 0) ? 0 : 3);
            chk_st(LPMC_ACTIVE);
        end
        ppb(1'b1, LPMC_SCR_ADDR, 32'h2, v);
        i_core.issue(4'h1);
        chk_st(LPMC_SLEEP);
        pulse(0);
        ppb(1'b1, LPMC_SCR_ADDR, 32'h0, v);
        i_core.issue(4'h1);
        chk_st(LPMC_ACTIVE);
        ppb(1'b1, LPMC_SCR_ADDR, 32'h10, v);
        i_core.issue(4'h8);
        pulse(1);
        chk_st(LPMC_ACTIVE);
        ppb(1'b1, LPMC_SCR_ADDR, 32'h0, v);
        i_core.issue(4'h8);
        pulse(1);
        chk_st(LPMC_SLEEP);
        pulse(0);
        pulse(2);
        chk({31'h0, event_latched}, 32'h1);
        i_core.issue(4'h4);
        chk_st(LPMC_ACTIVE);
        chk({31'h0, event_latched}, 32'h0);
        i_core.issue(4'h2);
        i_core.issue(4'h4);
        chk_st(LPMC_ACTIVE);
        i_core.issue(4'h4);
        chk_st(LPMC_SLEEP);
        pulse(2);
        chk_st(LPMC_ACTIVE);
        // random unmapped traffic, pin and disabled irq noise while active
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            external_wake_pin = seed[0];
            irq_pending_disabled = seed[3];
            ppb(seed[1], {seed[31:8], 8'h14}, seed, v);
            chk(v, 32'h0);
            power_management_unit(seed[2], {seed[11:5], 5'h18}, seed, v);
            chk(v, 32'h0);
            chk_st(LPMC_ACTIVE);
        end
        external_wake_pin = 1'b1;
        irq_pending_disabled = 1'b0;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            rv[i] = seed;
            power_management_unit(1'b1, LPMC_RET0_OFF + 12'(4 * i), seed, v);
        end
        power_management_unit(1'b1, LPMC_POWER_MODE_SELECT_REG_OFF, 32'h903, v);
        ppb(1'b1, LPMC_SCR_ADDR, 32'h4, v);
        i_core.issue(4'h8);
        chk_st(LPMC_DPD);
        pin_low();
        chk_st(LPMC_ACTIVE);
        chk(32'(n_reboot), 32'h1);
        power_management_unit(1'b0, LPMC_POWER_MODE_SELECT_REG_OFF, 32'h0, v); chk(v, 32'h800);
        for (int i = 0; i < 4; i++) begin
            power_management_unit(1'b0, LPMC_RET0_OFF + 12'(4 * i), 32'h0, v);
            chk(v, rv[i]);
        end
        power_management_unit(1'b1, LPMC_DPD_OFF, 32'h5, v);
        power_management_unit(1'b1, LPMC_POWER_MODE_SELECT_REG_OFF, 32'h3, v);
        i_core.issue(4'h8);
        pin_low();
        chk_st(LPMC_DPD);
        pulse(4);
        repeat (2) @(negedge clk);
        chk_st(LPMC_ACTIVE);
        chk(32'(n_reboot), 32'h2);
        report_and_stop();
    end
endmodule
bind lpmc_core lpmc_core_properties i_props (.*);
`default_nettype wire
